// ---- design/ofm_params.svh ----
// constants for the output function mapper: codes, offsets, reset values
`ifndef OFM_PARAMS_SVH
`define OFM_PARAMS_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define OFM_CHAN_N 6
`define OFM_FUNC_N 18
`define OFM_CODE_W 8

// ------------------------------------------------------------
// function codes: gp is 00, the rest odd code of each pair, even code is odd + 1 except for brake, which has none
// ------------------------------------------------------------
`define OFM_CODE_GP 8'h00
`define OFM_CODE_FAULT 8'h01
`define OFM_CODE_ALERT 8'h03
`define OFM_CODE_BRAKE 8'h05
`define OFM_CODE_SERVO_ON 8'h07
`define OFM_CODE_POS_DONE 8'h09
`define OFM_CODE_FOLLOW 8'h0b
`define OFM_CODE_TORQUE_REACHED 8'h0d
`define OFM_CODE_TQ_LIMIT 8'h0f
`define OFM_CODE_SPD_COIN 8'h11
`define OFM_CODE_SPD_REACH 8'h13
`define OFM_CODE_SPD_LIMIT 8'h15
`define OFM_CODE_READY 8'h17
`define OFM_CODE_ORIGIN 8'h19
`define OFM_CODE_FWD_LIMIT 8'h1b
`define OFM_CODE_REV_LIMIT 8'h1d
`define OFM_CODE_POS_COIN 8'h1f
`define OFM_CODE_ZERO_SPD 8'h21
`define OFM_CODE_TQ_COIN 8'h23

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFM_OFS_SEL1 8'h00
`define OFM_OFS_SEL2 8'h04
`define OFM_OFS_SEL3 8'h08
`define OFM_OFS_SEL4 8'h0c
`define OFM_OFS_SEL5 8'h10
`define OFM_OFS_SEL6 8'h14
`define OFM_OFS_GP_LEVEL 8'h18
`define OFM_OFS_CHAN_STATE 8'h1c
`define OFM_OFS_FUNC_STATE 8'h20

// ------------------------------------------------------------
// reset values of the selection settings
// ------------------------------------------------------------
`define OFM_RST_SEL1 8'h07
`define OFM_RST_SEL2 8'h17
`define OFM_RST_SEL3 8'h01
`define OFM_RST_SEL4 8'h09
`define OFM_RST_SEL5 8'h19
`define OFM_RST_SEL6 8'h0f
`define OFM_RST_GP_LEVEL 6'h00

`endif

// ---- design/ofm_pkg.sv ----
// types shared by the output function mapper
`include "ofm_params.svh"

package ofm_pkg;

    typedef logic [`OFM_CODE_W-1:0] ofm_code_t;
    typedef logic [`OFM_FUNC_N-1:0] ofm_status_t;
    typedef logic [`OFM_CHAN_N-1:0] ofm_chan_t;

    // bit position of each status function in the status vector
    typedef enum logic [4:0] {
        FN_FAULT = 5'h00,
        FN_ALERT = 5'h01,
        FN_BRAKE = 5'h02,
        FN_SERVO_ON = 5'h03,
        FN_POS_DONE = 5'h04,
        FN_FOLLOW = 5'h05,
        FN_TORQUE_REACHED = 5'h06,
        FN_TQ_LIMIT = 5'h07,
        FN_SPD_COIN = 5'h08,
        FN_SPD_REACH = 5'h09,
        FN_SPD_LIMIT = 5'h0a,
        FN_READY = 5'h0b,
        FN_ORIGIN = 5'h0c,
        FN_FWD_LIMIT = 5'h0d,
        FN_REV_LIMIT = 5'h0e,
        FN_POS_COIN = 5'h0f,
        FN_ZERO_SPD = 5'h10,
        FN_TQ_COIN = 5'h11
    } ofm_func_e;

    // odd code of each function, indexed by status bit position
    typedef ofm_code_t ofm_code_table_t [`OFM_FUNC_N];
    localparam ofm_code_table_t OFM_FUNC_CODE = '{
        `OFM_CODE_FAULT, `OFM_CODE_ALERT, `OFM_CODE_BRAKE, `OFM_CODE_SERVO_ON,
        `OFM_CODE_POS_DONE, `OFM_CODE_FOLLOW, `OFM_CODE_TORQUE_REACHED, `OFM_CODE_TQ_LIMIT,
        `OFM_CODE_SPD_COIN, `OFM_CODE_SPD_REACH, `OFM_CODE_SPD_LIMIT, `OFM_CODE_READY,
        `OFM_CODE_ORIGIN, `OFM_CODE_FWD_LIMIT, `OFM_CODE_REV_LIMIT, `OFM_CODE_POS_COIN,
        `OFM_CODE_ZERO_SPD, `OFM_CODE_TQ_COIN
    };

endpackage

// ---- design/ofm_chan_if.sv ----
// per-channel link between the register file and a channel decoder
`timescale 1ns/1ps
`default_nettype none

interface ofm_chan_if;
    import ofm_pkg::*;

    ofm_code_t code;
    ofm_status_t status;
    logic gp_level;
    logic conduct;

    modport mapper (
        input code,
        input status,
        input gp_level,
        output conduct
    );

    modport owner (
        output code,
        output status,
        output gp_level,
        input conduct
    );
endinterface

`default_nettype wire

// ---- design/ofm_chan_decode.sv ----
// decodes one selection code into the conduct level of one output switch
`timescale 1ns/1ps
`default_nettype none

`include "ofm_params.svh"

module ofm_chan_decode (
    ofm_chan_if.mapper ch
);
    import ofm_pkg::*;

    // ------------------------------------------------------------
    // code lookup
    // ------------------------------------------------------------
    // unknown codes fall through with conduct low, switch left open
    always_comb begin
        ch.conduct = 1'b0;
        if (ch.code == `OFM_CODE_GP) begin
            ch.conduct = ch.gp_level;
        end
        for (int i = 0; i < `OFM_FUNC_N; i++) begin
            if (ch.code == OFM_FUNC_CODE[i]) begin
                ch.conduct = ch.status[i];
            end
            // brake release has no inverted code
            if (i != int'(FN_BRAKE) && ch.code == OFM_FUNC_CODE[i] + 8'h01) begin
                ch.conduct = ~ch.status[i];
            end
        end
    end
endmodule

`default_nettype wire

// ---- design/ofm_top.sv ----
// output function mapper: ahb-lite register file and six routed output switches
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "ofm_params.svh"

module ofm_top (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire ofm_pkg::ofm_status_t FUNC_STATUS_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    output logic OUT_CHANNEL_1_OUT,
    output logic OUT_CHANNEL_2_OUT,
    output logic OUT_CHANNEL_3_OUT,
    output logic OUT_CHANNEL_4_OUT,
    output logic OUT_CHANNEL_5_OUT,
    output logic OUT_CHANNEL_6_OUT
);
    import ofm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ofm_code_t sel_r [`OFM_CHAN_N];
    ofm_chan_t gp_level_r;
    ofm_chan_t conduct_r;
    ofm_chan_t conduct_nxt;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic addr_phase;
    logic [31:0] rd_nxt;
    logic [31:0] wr_fwd;

    // ------------------------------------------------------------
    // ahb-lite address phase
    // ------------------------------------------------------------
    // only htrans[1] matters: nonseq and seq both carry a transfer
    assign addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (HREADY_IN) begin
            // upper address bits set: unmapped, so the write is dropped
            wr_pend_r <= addr_phase & HWRITE_IN & (HADDR_IN[31:8] == 24'h00_0000);
            wr_addr_r <= HADDR_IN[7:0];
        end
    end

    // slave never stalls and never errors
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes, data phase
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sel_r[0] <= `OFM_RST_SEL1;
            sel_r[1] <= `OFM_RST_SEL2;
            sel_r[2] <= `OFM_RST_SEL3;
            sel_r[3] <= `OFM_RST_SEL4;
            sel_r[4] <= `OFM_RST_SEL5;
            sel_r[5] <= `OFM_RST_SEL6;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `OFM_OFS_SEL1: sel_r[0] <= HWDATA_IN[`OFM_CODE_W-1:0];
                `OFM_OFS_SEL2: sel_r[1] <= HWDATA_IN[`OFM_CODE_W-1:0];
                `OFM_OFS_SEL3: sel_r[2] <= HWDATA_IN[`OFM_CODE_W-1:0];
                `OFM_OFS_SEL4: sel_r[3] <= HWDATA_IN[`OFM_CODE_W-1:0];
                `OFM_OFS_SEL5: sel_r[4] <= HWDATA_IN[`OFM_CODE_W-1:0];
                `OFM_OFS_SEL6: sel_r[5] <= HWDATA_IN[`OFM_CODE_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            gp_level_r <= `OFM_RST_GP_LEVEL;
        end else if (wr_pend_r && wr_addr_r == `OFM_OFS_GP_LEVEL) begin
            gp_level_r <= HWDATA_IN[`OFM_CHAN_N-1:0];
        end
    end

    // ------------------------------------------------------------
    // read data, registered at the address phase edge
    // ------------------------------------------------------------
    // a read right behind a write to the same word sees the new data
    always_comb begin
        wr_fwd = 32'h0000_0000;
        if (wr_pend_r) begin
            wr_fwd = HWDATA_IN;
        end
        rd_nxt = 32'h0000_0000;
        case (HADDR_IN[7:0])
            `OFM_OFS_SEL1: rd_nxt = {24'h00_0000, sel_r[0]};
            `OFM_OFS_SEL2: rd_nxt = {24'h00_0000, sel_r[1]};
            `OFM_OFS_SEL3: rd_nxt = {24'h00_0000, sel_r[2]};
            `OFM_OFS_SEL4: rd_nxt = {24'h00_0000, sel_r[3]};
            `OFM_OFS_SEL5: rd_nxt = {24'h00_0000, sel_r[4]};
            `OFM_OFS_SEL6: rd_nxt = {24'h00_0000, sel_r[5]};
            `OFM_OFS_GP_LEVEL: rd_nxt = {26'h000_0000, gp_level_r};
            `OFM_OFS_CHAN_STATE: rd_nxt = {26'h000_0000, conduct_r};
            `OFM_OFS_FUNC_STATE: rd_nxt = {14'h0000, FUNC_STATUS_IN};
            default: rd_nxt = 32'h0000_0000;
        endcase
        if (HADDR_IN[31:8] != 24'h00_0000) begin
            rd_nxt = 32'h0000_0000;
        end else if (wr_pend_r && wr_addr_r == HADDR_IN[7:0]) begin
            case (HADDR_IN[7:0])
                `OFM_OFS_SEL1, `OFM_OFS_SEL2, `OFM_OFS_SEL3,
                `OFM_OFS_SEL4, `OFM_OFS_SEL5, `OFM_OFS_SEL6:
                    rd_nxt = {24'h00_0000, wr_fwd[`OFM_CODE_W-1:0]};
                `OFM_OFS_GP_LEVEL: rd_nxt = {26'h000_0000, wr_fwd[`OFM_CHAN_N-1:0]};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            HRDATA_OUT <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE_IN) begin
            HRDATA_OUT <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // channel decoders
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < `OFM_CHAN_N; g++) begin : gen_chan
            ofm_chan_if chan ();
            assign chan.code = sel_r[g];
            assign chan.status = FUNC_STATUS_IN;
            assign chan.gp_level = gp_level_r[g];
            assign conduct_nxt[g] = chan.conduct;
            ofm_chan_decode u_dec (
                .ch(chan.mapper)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // output switches, 1 = conducting
    // ------------------------------------------------------------
    // one cycle of latency buys glitch-free pins
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            conduct_r <= 6'h00;
        end else begin
            conduct_r <= conduct_nxt;
        end
    end

    assign OUT_CHANNEL_1_OUT = conduct_r[0];
    assign OUT_CHANNEL_2_OUT = conduct_r[1];
    assign OUT_CHANNEL_3_OUT = conduct_r[2];
    assign OUT_CHANNEL_4_OUT = conduct_r[3];
    assign OUT_CHANNEL_5_OUT = conduct_r[4];
    assign OUT_CHANNEL_6_OUT = conduct_r[5];
endmodule

`default_nettype wire

// ---- dv/ofm_top_chk.sv ----
// port checker for the output function mapper, bound to its top
`timescale 1ns/1ps
`default_nettype none

module ofm_top_chk (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire ofm_pkg::ofm_status_t FUNC_STATUS_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic OUT_CHANNEL_1_OUT,
    input wire logic OUT_CHANNEL_2_OUT,
    input wire logic OUT_CHANNEL_3_OUT,
    input wire logic OUT_CHANNEL_4_OUT,
    input wire logic OUT_CHANNEL_5_OUT,
    input wire logic OUT_CHANNEL_6_OUT
);
    import ofm_pkg::*;
    logic wr_q;
    logic rd_q;
    logic [31:0] ad_q;
    ofm_code_t sel_r [6];
    logic [5:0] gp_r;
    logic [5:0] exp_c;
    logic [5:0] exp_r;

    function automatic logic dec(ofm_code_t c, ofm_status_t s, logic g);
        if (c == 8'h00) return g;
        if (c == 8'h06 || c > 8'h24) return 1'b0;
        return c[0] ? s[(c - 1) >> 1] : !s[(c - 1) >> 1];
    endfunction

    always_comb begin
        for (int k = 0; k < 6; k++) begin
            exp_c[k] = dec(sel_r[k], FUNC_STATUS_IN, gp_r[k]);
        end
    end

    // shadow of the selection settings, rebuilt from the bus traffic
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ad_q <= 32'h0;
            sel_r <= '{8'h07, 8'h17, 8'h01, 8'h09, 8'h19, 8'h0f};
            gp_r <= 6'h00;
            exp_r <= 6'h00;
        end else begin
            exp_r <= exp_c;
            if (wr_q && HREADY_IN && ad_q[31:5] == 27'h0 && ad_q[4:2] < 3'h6) begin
                sel_r[ad_q[4:2]] <= HWDATA_IN[7:0];
            end
            if (wr_q && HREADY_IN && ad_q == 32'h18) begin
                gp_r <= HWDATA_IN[5:0];
            end
            if (HREADY_IN) begin
                wr_q <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
                rd_q <= HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;
                ad_q <= HADDR_IN;
            end
        end
    end

    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (RESET_IN);

    a_bus_ready: assert property (HREADYOUT_OUT) else $error("hreadyout low");
    a_resp_okay: assert property (!HRESP_OUT) else $error("error response");
    a_ch1_level: assert property (OUT_CHANNEL_1_OUT == exp_r[0]) else $error("ch1");
    a_ch2_level: assert property (OUT_CHANNEL_2_OUT == exp_r[1]) else $error("ch2");
    a_ch3_level: assert property (OUT_CHANNEL_3_OUT == exp_r[2]) else $error("ch3");
    a_ch4_level: assert property (OUT_CHANNEL_4_OUT == exp_r[3]) else $error("ch4");
    a_ch5_level: assert property (OUT_CHANNEL_5_OUT == exp_r[4]) else $error("ch5");
    a_ch6_level: assert property (OUT_CHANNEL_6_OUT == exp_r[5]) else $error("ch6");
    a_brake_code: assert property (sel_r[4] == 8'h05 |=>
        OUT_CHANNEL_5_OUT == $past(FUNC_STATUS_IN[2])) else $error("brake code");
    a_open_code: assert property (sel_r[5] == 8'h06 |=> !OUT_CHANNEL_6_OUT) else $error("code 6");
    a_stat_read: assert property (rd_q && ad_q == 32'h20 |->
        HRDATA_OUT == {14'h0, $past(FUNC_STATUS_IN)}) else $error("status read");
endmodule

bind ofm_top ofm_top_chk u_chk (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .FUNC_STATUS_IN(FUNC_STATUS_IN),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .OUT_CHANNEL_1_OUT(OUT_CHANNEL_1_OUT), .OUT_CHANNEL_2_OUT(OUT_CHANNEL_2_OUT),
    .OUT_CHANNEL_3_OUT(OUT_CHANNEL_3_OUT), .OUT_CHANNEL_4_OUT(OUT_CHANNEL_4_OUT),
    .OUT_CHANNEL_5_OUT(OUT_CHANNEL_5_OUT), .OUT_CHANNEL_6_OUT(OUT_CHANNEL_6_OUT));

`default_nettype wire

// ---- dv/ofm_ctrl_model.sv ----
// external controller inputs watching the six output switches
`timescale 1ns/1ps
`default_nettype none

module ofm_ctrl_model (
    input wire logic clk_in,
    input wire logic [5:0] pins_in,
    output logic [5:0] seen_out
);
    // input sees a loop only while the switch conducts; one flop of input filtering
    always_ff @(posedge clk_in) begin
        seen_out <= pins_in;
    end
endmodule

`default_nettype wire

// ---- dv/ofm_top_tb.sv ----
// self-checking bench for the output function mapper
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    checks_done++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end

module ofm_top_tb;
    import ofm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    ofm_status_t st = '0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [5:0] pins;
    logic [5:0] seen;
    logic rd_dp = 1'b0;
    logic [32:0] expq [$];
    logic [32:0] e;
    int num_errors = 0;
    int checks_done = 0;
    ofm_code_t code [6];
    ofm_code_t rv [6] = '{8'h07, 8'h17, 8'h01, 8'h09, 8'h19, 8'h0f};
    logic [5:0] gp;
    logic [5:0] ev;

    ofm_top DUT (.MCLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .FUNC_STATUS_IN(st), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .OUT_CHANNEL_1_OUT(pins[0]),
        .OUT_CHANNEL_2_OUT(pins[1]), .OUT_CHANNEL_3_OUT(pins[2]),
        .OUT_CHANNEL_4_OUT(pins[3]), .OUT_CHANNEL_5_OUT(pins[4]),
        .OUT_CHANNEL_6_OUT(pins[5]));
    ofm_ctrl_model u_ctrl (.clk_in(clk), .pins_in(pins), .seen_out(seen));

    initial begin
        forever #10 clk = ~clk;
    end

    function automatic logic dec(ofm_code_t c, ofm_status_t s, logic g);
        if (c == 8'h00) return g;
        if (c == 8'h06 || c > 8'h24) return 1'b0;
        return c[0] ? s[(c - 1) >> 1] : !s[(c - 1) >> 1];
    endfunction

    // one single ahb transfer; x is the expected read word, bit 32 asks for a pin check
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [32:0] x);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        if (!w) expq.push_back(x);
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd_dp <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (rd_dp && hready === 1'b1) begin
            e = expq.pop_front();
            `CHK("read data", e[31:0], hrdata)
            if (e[32]) begin
                `CHK("controller view", e[5:0], seen)
            end
        end
    end

    task automatic final_report;
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        final_report;
    end

    initial begin
        void'($urandom(32'hb963d14b));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) xfer(1'b0, k * 4, 32'h0, {25'h0, rv[k]});
        xfer(1'b1, 32'h24, $urandom, 33'h0);
        xfer(1'b0, 32'h24, 32'h0, 33'h0);
        xfer(1'b0, 32'h100, 32'h0, 33'h0);
        // a write above the decoded window must not alias onto channel 1
        xfer(1'b1, 32'h100, 32'h0, 33'h0);
        xfer(1'b0, 32'h0, 32'h0, {25'h0, rv[0]});
        // every channel walks every code 0..40 against random status
        for (int i = 0; i < 41; i++) begin
            st <= ofm_status_t'($urandom);
            gp = 6'($urandom);
            xfer(1'b1, 32'h18, {26'h0, gp}, 33'h0);
            for (int k = 0; k < 6; k++) begin
                code[k] = 8'((i + 7 * k) % 41);
                xfer(1'b1, k * 4, {24'h0, code[k]}, 33'h0);
            end
            for (int k = 0; k < 6; k++) ev[k] = dec(code[k], st, gp[k]);
            xfer(1'b0, 32'h14, 32'h0, {25'h0, code[5]});
            xfer(1'b0, 32'h18, 32'h0, {27'h0, gp});
            xfer(1'b0, 32'h20, 32'h0, {15'h0, st});
            xfer(1'b0, 32'h1c, 32'h0, {1'b1, 26'h0, ev});
        end
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, 32'h0, 32'h0, {25'h0, rv[0]});
        // after the mid-run reset the pins follow the reset codes again
        for (int k = 0; k < 6; k++) ev[k] = dec(rv[k], st, 1'b0);
        xfer(1'b0, 32'h1c, 32'h0, {1'b1, 26'h0, ev});
        final_report;
    end
endmodule

`default_nettype wire
